// ---- src/breaker_pkg.sv ----
// Behaviour
// - panel requests need local permission
// - remote requests need remote permission
// - close executes only with sync permit
// - open executes only with open interlock
// - close executes only with close interlock
// - block input stops every operation
// - external switching only masks unintended operation
// - executed request drives matching command pulse
// - pulse 100-1000 ms, early end, floor 100
// - sync missing past wait starts synchro-switch
// - sync wait 10-5000 ms; zero suppresses switch
// - each operation gives 150 ms pulse
// - status change without command flags unintended
// - filtered opened and closed outputs
// - unsettled status past wait reports intermediate
// - counter counts each operation pulse start
// - counter clears on reset request
// - state change raises a status event
// - state code 0 mid,1 off,2 on,3 bad
// - one off/on channel drives pulses
package breaker_pkg;

   localparam int CLK_PERIOD_NS = 32'h0000_0008;
   localparam int NS_PER_MS     = 32'h000F_4240;
   localparam int TICK_MS       = 32'h0000_0001;
   localparam int MS_CYCLES_DEF = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int TICK_W        = 32'h0000_0011;
   localparam int MS_W          = 32'h0000_0010;
   localparam int CNT_W         = 32'h0000_0010;

   typedef logic [MS_W-1:0] ms_t;

   localparam ms_t PULSE_FLOOR_MS  = 16'h0064;
   localparam ms_t PULSE_MAX_MS    = 16'h03E8;
   localparam ms_t SYNCHK_MIN_MS   = 16'h000A;
   localparam ms_t SYNCHK_MAX_MS   = 16'h1388;
   localparam ms_t SYNSW_MAX_MS    = 16'hEA60;
   localparam ms_t INTERMED_MIN_MS = 16'h0014;
   localparam ms_t INTERMED_MAX_MS = 16'h01F4;
   localparam ms_t OPER_MS         = 16'h0096;

   typedef enum logic [1:0] {
      ST_INTERMEDIATE = 2'h0,
      ST_OFF          = 2'h1,
      ST_ON           = 2'h2,
      ST_BAD          = 2'h3
   } cb_state_t;

   typedef enum logic [4:0] {
      SEQ_IDLE      = 5'h01,
      SEQ_WAIT_SYNC = 5'h02,
      SEQ_SWITCH    = 5'h04,
      SEQ_OPEN      = 5'h08,
      SEQ_CLOSE     = 5'h10
   } seq_t;

   typedef struct packed {
      logic valid;
      logic close;
   } cmd_req_t;

   typedef struct packed {
      logic local_permit;
      logic remote_permit;
      logic sync_permit;
      logic open_interlock_ok;
      logic close_interlock_ok;
      logic block_operation;
   } permit_t;

   typedef struct packed {
      ms_t pulse_ms;
      ms_t synchk_ms;
      ms_t synsw_ms;
      ms_t intermed_ms;
   } settings_t;

endpackage

// ---- src/ms_timer.sv ----
`timescale 1ns/100ps
module ms_timer #(
   parameter int W = 16
) (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic         restart,
   input  wire logic         tick,
   output logic [W-1:0]      elapsed
);

   // saturates so a long idle never wraps back under a limit
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         elapsed <= '0;
      end else if (restart) begin
         elapsed <= '0;
      end else if (tick && elapsed != '1) begin
         elapsed <= elapsed + 1'b1;
      end
   end

endmodule

// ---- src/breaker_command_gate.sv ----
`timescale 1ns/100ps
module breaker_command_gate #(
   parameter int MS_CYCLES = breaker_pkg::MS_CYCLES_DEF
) (
   input  wire logic                   clock,
   input  wire logic                   rstn,
   input  wire breaker_pkg::cmd_req_t  panel_request,
   input  wire breaker_pkg::cmd_req_t  operate_command_channel,
   input  wire breaker_pkg::permit_t   permits,
   input  wire logic                   status_open_in,
   input  wire logic                   status_closed_in,
   input  wire logic                   external_switching,
   input  wire breaker_pkg::settings_t settings,
   input  wire logic                   count_clear,
   output logic                        open_pulse,
   output logic                        close_pulse,
   output logic                        synchro_switch_start,
   output logic                        operation_pulse,
   output logic                        unintended_operation,
   output logic                        opened,
   output logic                        closed,
   output breaker_pkg::cb_state_t      breaker_state_code,
   output logic                        state_event,
   output logic [breaker_pkg::CNT_W-1:0] operation_count
);

   function automatic breaker_pkg::ms_t clamp(
      input breaker_pkg::ms_t v,
      input breaker_pkg::ms_t lo,
      input breaker_pkg::ms_t hi
   );
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic [breaker_pkg::TICK_W-1:0] prescale;
   logic                           tick;
   breaker_pkg::seq_t              state;
   breaker_pkg::seq_t              next_state;
   breaker_pkg::cb_state_t         next_code;
   breaker_pkg::ms_t               seq_ms;
   breaker_pkg::ms_t               mid_ms;
   breaker_pkg::ms_t               oper_ms;
   logic                           cmd_seen;
   logic                           ext_seen;

   // 1 ms tick shared by all timers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prescale <= '0;
         tick     <= 1'b0;
      end else if (prescale == breaker_pkg::TICK_W'(MS_CYCLES - 1)) begin
         prescale <= '0;
         tick     <= 1'b1;
      end else begin
         prescale <= prescale + 1'b1;
         tick     <= 1'b0;
      end
   end

   // settings held to their ranges; pulse below 100 ms is raised to it
   wire breaker_pkg::ms_t pulse_eff = clamp(settings.pulse_ms,
      breaker_pkg::PULSE_FLOOR_MS, breaker_pkg::PULSE_MAX_MS);
   wire breaker_pkg::ms_t synchk_eff = clamp(settings.synchk_ms,
      breaker_pkg::SYNCHK_MIN_MS, breaker_pkg::SYNCHK_MAX_MS);
   wire breaker_pkg::ms_t synsw_eff = clamp(settings.synsw_ms,
      16'h0000, breaker_pkg::SYNSW_MAX_MS);
   wire breaker_pkg::ms_t intermed_eff = clamp(settings.intermed_ms,
      breaker_pkg::INTERMED_MIN_MS, breaker_pkg::INTERMED_MAX_MS);

   // panel wins when both sources ask in one cycle
   wire use_panel = panel_request.valid;
   wire breaker_pkg::cmd_req_t req =
      use_panel ? panel_request : operate_command_channel;
   wire req_valid = panel_request.valid | operate_command_channel.valid;
   wire src_ok = use_panel ? permits.local_permit
                           : permits.remote_permit;
   wire gate_ok = req_valid && src_ok && !permits.block_operation;
   wire open_ok = gate_ok && !req.close
                  && permits.open_interlock_ok;
   wire close_ok = gate_ok && req.close
                   && permits.close_interlock_ok;
   wire close_hold = permits.close_interlock_ok
                     && !permits.block_operation;
   wire open_done = status_open_in && !status_closed_in;
   wire close_done = status_closed_in && !status_open_in;
   wire seq_restart = next_state != state;
   wire pulse_floor = seq_ms > breaker_pkg::PULSE_FLOOR_MS;
   wire idle_expired = state == breaker_pkg::SEQ_IDLE && seq_ms > pulse_eff;

   always_comb begin
      next_state = state;
      case (state)
         breaker_pkg::SEQ_IDLE: begin
            if (open_ok) begin
               next_state = breaker_pkg::SEQ_OPEN;
            end else if (close_ok && permits.sync_permit) begin
               next_state = breaker_pkg::SEQ_CLOSE;
            end else if (close_ok) begin
               next_state = breaker_pkg::SEQ_WAIT_SYNC;
            end
         end
         breaker_pkg::SEQ_WAIT_SYNC: begin
            if (!close_hold) begin
               next_state = breaker_pkg::SEQ_IDLE;
            end else if (permits.sync_permit) begin
               next_state = breaker_pkg::SEQ_CLOSE;
            end else if (seq_ms > synchk_eff) begin
               // zero switch wait means give up quietly
               next_state = (synsw_eff != 16'h0000)
                  ? breaker_pkg::SEQ_SWITCH
                  : breaker_pkg::SEQ_IDLE;
            end
         end
         breaker_pkg::SEQ_SWITCH: begin
            if (!close_hold || seq_ms > synsw_eff) begin
               next_state = breaker_pkg::SEQ_IDLE;
            end else if (permits.sync_permit) begin
               next_state = breaker_pkg::SEQ_CLOSE;
            end
         end
         breaker_pkg::SEQ_OPEN: begin
            if (permits.block_operation || seq_ms > pulse_eff
                || (pulse_floor && open_done)) begin
               next_state = breaker_pkg::SEQ_IDLE;
            end
         end
         breaker_pkg::SEQ_CLOSE: begin
            if (permits.block_operation || seq_ms > pulse_eff
                || (pulse_floor && close_done)) begin
               next_state = breaker_pkg::SEQ_IDLE;
            end
         end
         default: begin
            next_state = breaker_pkg::SEQ_IDLE;
         end
      endcase
   end

   ms_timer #(.W(breaker_pkg::MS_W)) seq_timer (
      .clock   (clock),
      .rstn    (rstn),
      .restart (seq_restart),
      .tick    (tick),
      .elapsed (seq_ms)
   );

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state                <= breaker_pkg::SEQ_IDLE;
         open_pulse           <= 1'b0;
         close_pulse          <= 1'b0;
         synchro_switch_start <= 1'b0;
      end else begin
         state                <= next_state;
         open_pulse           <= next_state == breaker_pkg::SEQ_OPEN;
         close_pulse          <= next_state == breaker_pkg::SEQ_CLOSE;
         synchro_switch_start <= next_state == breaker_pkg::SEQ_SWITCH;
      end
   end

   // status filter: a lone intermediate code is held until its wait runs out
   wire breaker_pkg::cb_state_t raw_code =
      breaker_pkg::cb_state_t'({status_closed_in, status_open_in});
   wire mid_restart = raw_code != breaker_pkg::ST_INTERMEDIATE;

   ms_timer #(.W(breaker_pkg::MS_W)) mid_timer (
      .clock   (clock),
      .rstn    (rstn),
      .restart (mid_restart),
      .tick    (tick),
      .elapsed (mid_ms)
   );

   always_comb begin
      if (mid_restart) begin
         next_code = raw_code;
      end else if (mid_ms > intermed_eff) begin
         next_code = breaker_pkg::ST_INTERMEDIATE;
      end else begin
         next_code = breaker_state_code;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         breaker_state_code <= breaker_pkg::ST_INTERMEDIATE;
         state_event        <= 1'b0;
         opened             <= 1'b0;
         closed             <= 1'b0;
      end else begin
         breaker_state_code <= next_code;
         state_event        <= next_code != breaker_state_code;
         opened             <= next_code == breaker_pkg::ST_OFF;
         closed             <= next_code == breaker_pkg::ST_ON;
      end
   end

   // an operation is a filtered move between off and on
   wire oper_event =
      (breaker_state_code == breaker_pkg::ST_OFF
       && next_code == breaker_pkg::ST_ON)
      || (breaker_state_code == breaker_pkg::ST_ON
       && next_code == breaker_pkg::ST_OFF);
   wire oper_start = oper_event && !operation_pulse;
   wire cmd_now = next_state == breaker_pkg::SEQ_OPEN
                  || next_state == breaker_pkg::SEQ_CLOSE;

   ms_timer #(.W(breaker_pkg::MS_W)) oper_timer (
      .clock   (clock),
      .rstn    (rstn),
      .restart (oper_event),
      .tick    (tick),
      .elapsed (oper_ms)
   );

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         operation_pulse <= 1'b0;
      end else if (oper_event) begin
         operation_pulse <= 1'b1;
      end else if (oper_ms > breaker_pkg::OPER_MS) begin
         operation_pulse <= 1'b0;
      end
   end

   // a clear in the same cycle as a start still counts the start
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         operation_count <= '0;
      end else if (oper_start) begin
         operation_count <= count_clear ? breaker_pkg::CNT_W'(1)
                          : operation_count + 1'b1;
      end else if (count_clear) begin
         operation_count <= '0;
      end
   end

   // commands stay credited one pulse length after the sequence idles,
   // so a slow breaker is not flagged; set wins over expiry
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cmd_seen <= 1'b0;
         ext_seen <= 1'b0;
      end else begin
         cmd_seen <= cmd_now
                     || (cmd_seen && !oper_event && !idle_expired);
         ext_seen <= external_switching
                     || (ext_seen && !oper_event && !idle_expired);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         unintended_operation <= 1'b0;
      end else if (oper_event) begin
         unintended_operation <= !(cmd_seen || cmd_now || ext_seen
                                   || external_switching);
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_blocked;
      permits.block_operation;
   endsequence

   sequence s_panel_refused;
      state == breaker_pkg::SEQ_IDLE && panel_request.valid
      && !permits.local_permit;
   endsequence

   sequence s_remote_refused;
      state == breaker_pkg::SEQ_IDLE && !panel_request.valid
      && operate_command_channel.valid && !permits.remote_permit;
   endsequence

   AST_BLOCK_STOPS_PULSES: assert property (
      s_blocked |=> !open_pulse && !close_pulse)
      else $error("pulse active while operation blocked");

   AST_PANEL_NEEDS_LOCAL: assert property (
      s_panel_refused |=> !$rose(open_pulse) && !$rose(close_pulse)
                          && state == breaker_pkg::SEQ_IDLE)
      else $error("panel request taken without local permission");

   AST_REMOTE_NEEDS_PERMIT: assert property (
      s_remote_refused |=> state == breaker_pkg::SEQ_IDLE && !open_pulse)
      else $error("remote request taken without remote permission");

   AST_OPEN_INTERLOCK: assert property (
      $rose(open_pulse) |-> $past(permits.open_interlock_ok))
      else $error("open pulse without open interlock");

   AST_CLOSE_CONDITIONS: assert property (
      $rose(close_pulse) |-> $past(permits.sync_permit)
                            && $past(permits.close_interlock_ok))
      else $error("close pulse without sync or interlock");

   AST_PULSE_FLOOR: assert property (
      $fell(open_pulse) && !$past(permits.block_operation)
      |-> $past(seq_ms) > breaker_pkg::PULSE_FLOOR_MS)
      else $error("open pulse shorter than floor");

   AST_SWITCH_START: assert property (
      $rose(synchro_switch_start) |-> $past(synsw_eff) != 16'h0000
         && $past(seq_ms) > $past(synchk_eff) && !$past(permits.sync_permit))
      else $error("synchro-switch start at wrong moment");

   AST_OPER_LENGTH: assert property (
      $fell(operation_pulse) |-> $past(oper_ms) > breaker_pkg::OPER_MS)
      else $error("operation pulse ended early");

   AST_COUNT_STEP: assert property (
      $rose(operation_pulse) && !$past(count_clear)
      |-> operation_count == $past(operation_count) + 1'b1)
      else $error("counter did not step on operation");

   AST_COUNT_CLEAR: assert property (
      count_clear && !oper_start |=> operation_count == '0)
      else $error("counter not cleared");

   AST_STATE_EVENT: assert property (
      state_event |-> breaker_state_code != $past(breaker_state_code))
      else $error("status event without state change");

   AST_UNINTENDED_CAUSE: assert property (
      $rose(unintended_operation) |-> $past(oper_event)
         && !$past(external_switching) && !$past(cmd_seen))
      else $error("unintended flag without uncommanded change");

endmodule

// ---- tb/breaker_model.sv ----
`timescale 1ns/100ps
module breaker_model #(
   parameter int MS_CYCLES = 10
) (
   input  wire logic        clock,
   input  wire logic        open_pulse,
   input  wire logic        close_pulse,
   input  wire logic        stuck,
   input  wire logic [15:0] move_ms,
   output logic             status_open_in,
   output logic             status_closed_in
);
   int   travel;
   logic target_closed;
   initial begin
      status_open_in   = 1'b1;
      status_closed_in = 1'b0;
      target_closed    = 1'b0;
      travel           = 0;
   end
   // contacts part at once, settle after the travel time
   always @(posedge clock) begin
      if (travel > 0) begin
         travel <= travel - 1;
         if (travel == 1) begin
            status_open_in   <= ~target_closed;
            status_closed_in <= target_closed;
         end
      end else if (!stuck && ((open_pulse && !status_open_in) ||
                              (close_pulse && !status_closed_in))) begin
         target_closed    <= close_pulse;
         travel           <= move_ms * MS_CYCLES;
         status_open_in   <= 1'b0;
         status_closed_in <= 1'b0;
      end
   end
   // moves not caused by the gate, e.g. a protection trip
   task automatic set_contacts(input logic o, input logic c);
      status_open_in   <= o;
      status_closed_in <= c;
   endtask
endmodule

// ---- tb/breaker_command_gate_tb_top.sv ----
`timescale 1ns/100ps
module breaker_command_gate_tb_top;
   localparam int         MSC     = 10;
   localparam logic [2:0] K_OPEN  = 3'h0;
   localparam logic [2:0] K_CLOSE = 3'h1;
   localparam logic [2:0] K_SWST  = 3'h2;
   localparam logic [2:0] K_STATE = 3'h3;
   localparam logic [2:0] K_OPER  = 3'h4;
   localparam logic [2:0] K_WIDTH = 3'h5;
   localparam logic [5:0] BAD_P [6] = '{6'h1E, 6'h2E, 6'h3A, 6'h3C, 6'h3F,
                                        6'h3F};
   localparam logic [5:0] BAD_C = 6'h29;
   typedef struct packed {
      logic [2:0]  kind;
      logic [16:0] val;
   } note_t;
   logic                          clock, rstn, external_switching;
   logic                          count_clear, stuck;
   logic                          status_open_in, status_closed_in;
   logic                          open_pulse, close_pulse, state_event;
   logic                          synchro_switch_start, operation_pulse;
   logic                          unintended_operation, opened, closed;
   logic                          prev_open, prev_close, prev_sw, prev_oper;
   logic                          st_off, st_on;
   logic [15:0]                   move_ms;
   breaker_pkg::cmd_req_t         panel_request, operate_command_channel;
   breaker_pkg::permit_t          permits;
   breaker_pkg::settings_t        settings;
   breaker_pkg::cb_state_t        breaker_state_code;
   logic [breaker_pkg::CNT_W-1:0] operation_count;
   note_t                         notes[$];
   int                            err_total, comparisons, hi_cycles, oper_cyc;

   breaker_command_gate #(.MS_CYCLES(MSC)) breaker_command_gate_i (
      .clock(clock), .rstn(rstn), .panel_request(panel_request),
      .operate_command_channel(operate_command_channel),
      .permits(permits), .status_open_in(status_open_in),
      .status_closed_in(status_closed_in),
      .external_switching(external_switching), .settings(settings),
      .count_clear(count_clear), .open_pulse(open_pulse),
      .close_pulse(close_pulse),
      .synchro_switch_start(synchro_switch_start),
      .operation_pulse(operation_pulse),
      .unintended_operation(unintended_operation), .opened(opened),
      .closed(closed), .breaker_state_code(breaker_state_code),
      .state_event(state_event), .operation_count(operation_count));

   breaker_model #(.MS_CYCLES(MSC)) breaker_model_i (
      .clock(clock), .open_pulse(open_pulse), .close_pulse(close_pulse),
      .stuck(stuck), .move_ms(move_ms), .status_open_in(status_open_in),
      .status_closed_in(status_closed_in));

   function automatic bit hi(input logic x);
      return x === 1'b1;
   endfunction

   task automatic tally_and_finish;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic bad(input string n, input logic [16:0] e, g);
      err_total++;
      $display("BAD %s expected %0d seen %0d", n, e, g);
   endtask

   task automatic check_val(input string n, input logic [16:0] e, g);
      comparisons++;
      if (g !== e)
         bad(n, e, g);
   endtask

   // tick phase allows one ms either way
   task automatic check_near(input string n, input logic [16:0] e, g);
      comparisons++;
      if (g + 1 < e || g > e + 1)
         bad(n, e, g);
   endtask

   task automatic push(input logic [2:0] k, input logic [16:0] v);
      notes.push_back('{k, v});
   endtask

   task automatic take(input logic [2:0] k, input logic [16:0] v);
      note_t n;
      if (notes.size() == 0) begin
         bad("unexpected", 17'h0, {14'h0, k});
         return;
      end
      n = notes.pop_front();
      check_val("kind", {14'h0, n.kind}, {14'h0, k});
      if (k == K_WIDTH)
         check_near("width_ms", n.val, v);
      else
         check_val("value", n.val, v);
   endtask

   always @(negedge clock) begin
      if (hi(rstn)) begin
         if (hi(open_pulse) && !hi(prev_open))
            take(K_OPEN, 17'h0);
         if (hi(close_pulse) && !hi(prev_close))
            take(K_CLOSE, 17'h0);
         if (hi(synchro_switch_start) && !hi(prev_sw))
            take(K_SWST, 17'h0);
         if (hi(state_event))
            take(K_STATE, {15'h0, breaker_state_code});
         if (hi(state_event)) begin
            // filtered flags follow every code, bad and intermediate too
            st_off = breaker_state_code == breaker_pkg::ST_OFF;
            st_on  = breaker_state_code == breaker_pkg::ST_ON;
            check_val("opened", {16'h0, st_off}, {16'h0, opened});
            check_val("closed", {16'h0, st_on}, {16'h0, closed});
         end
         if (hi(operation_pulse) && !hi(prev_oper))
            take(K_OPER, {unintended_operation, operation_count});
         if (hi(prev_oper) && !hi(operation_pulse))
            check_near("oper", 17'h0_0097, 17'(oper_cyc / MSC));
         oper_cyc = hi(operation_pulse) ? oper_cyc + 1 : 0;
         if ((hi(prev_open) || hi(prev_close)) && !hi(open_pulse) &&
             !hi(close_pulse))
            take(K_WIDTH, 17'(hi_cycles / MSC));
         hi_cycles = (hi(open_pulse) || hi(close_pulse)) ? hi_cycles + 1 : 0;
      end
      prev_open  = open_pulse;
      prev_close = close_pulse;
      prev_sw    = synchro_switch_start;
      prev_oper  = operation_pulse;
   end

   task automatic send(input logic remote, input logic cls);
      @(negedge clock);
      if (remote)
         operate_command_channel = '{1'b1, cls};
      else
         panel_request = '{1'b1, cls};
      @(negedge clock);
      panel_request           = '0;
      operate_command_channel = '0;
   endtask

   // bounded wait for every noted result and every pulse to end
   task automatic settle(input int extra_ms);
      int n;
      n = 0;
      while (notes.size() != 0 || hi(open_pulse) || hi(close_pulse) ||
             hi(operation_pulse) || hi(synchro_switch_start)) begin
         @(negedge clock);
         n++;
         if (n > 6000) begin
            bad("timeout", 17'h0, 17'(notes.size()));
            tally_and_finish();
         end
      end
      repeat (extra_ms * MSC) @(negedge clock);
   endtask

   task automatic operate(input logic remote, cls, input logic [15:0] cnt);
      move_ms = 16'h0005 + 16'($urandom_range(9));
      push(cls ? K_CLOSE : K_OPEN, 17'h0);
      push(K_STATE, cls ? 17'h0_0002 : 17'h0_0001);
      push(K_OPER, {1'b0, cnt});
      push(K_WIDTH, 17'h0_0065); // early end well before 300
      send(remote, cls);
      settle(2);
   endtask

   task automatic self_move(input logic o, c, x, input logic [16:0] st, op);
      external_switching = x;
      push(K_STATE, st);
      push(K_OPER, op);
      breaker_model_i.set_contacts(o, c);
      settle(2);
      external_switching = 1'b0;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      rstn                    = 1'b0;
      panel_request           = '0;
      operate_command_channel = '0;
      permits                 = 6'h3E;
      settings                = {16'h012C, 16'h000A, 16'h001E, 16'h0014};
      external_switching      = 1'b0;
      count_clear             = 1'b0;
      stuck                   = 1'b0;
      move_ms                 = 16'h0005;
      err_total               = 0;
      comparisons             = 0;
      hi_cycles               = 0;
      oper_cyc                = 0;
      void'($urandom(32'h0000_fa2a));
      push(K_STATE, 17'h0_0001);
      repeat (2) @(negedge clock);
      check_val("count", 17'h0, {1'b0, operation_count});
      rstn = 1'b1;
      settle(2);
      for (int i = 0; i < 6; i++) begin
         permits = BAD_P[i];
         send(i[0], BAD_C[i]);
         repeat (30 + $urandom_range(20)) @(negedge clock);
      end
      // both sources at once: panel wins, so no local permit means refusal
      permits = BAD_P[0];
      @(negedge clock);
      panel_request           = '{1'b1, 1'b1};
      operate_command_channel = '{1'b1, 1'b1};
      @(negedge clock);
      panel_request           = '0;
      operate_command_channel = '0;
      repeat (20) @(negedge clock);
      permits = 6'h3E;
      operate(1'b0, 1'b1, 16'h0001);
      operate(1'b1, 1'b0, 16'h0002);
      stuck = 1'b1;
      for (int i = 0; i < 2; i++) begin
         settings.pulse_ms = i ? 16'h0096 : 16'h0032;
         push(K_CLOSE, 17'h0);
         push(K_WIDTH, i ? 17'h0_0097 : 17'h0_0065);
         send(i[0], 1'b1);
         settle(2);
      end
      stuck             = 1'b0;
      settings.pulse_ms = 16'h012C;
      for (int i = 0; i < 2; i++) begin
         settings.synsw_ms   = i ? 16'h001E : 16'h0000;
         permits.sync_permit = 1'b0;
         if (i)
            push(K_SWST, 17'h0);
         send(1'b0, 1'b1);
         repeat ((i ? 15 : 40) * MSC) @(negedge clock);
         if (i) begin
            push(K_CLOSE, 17'h0);
            push(K_STATE, 17'h0_0002);
            push(K_OPER, 17'h0_0003);
            push(K_WIDTH, 17'h0_0065);
         end
         permits.sync_permit = 1'b1;
         settle(2);
      end
      settle(320); // no command credit left
      self_move(1'b1, 1'b0, 1'b0, 17'h0_0001, 17'h1_0004);
      self_move(1'b0, 1'b1, 1'b1, 17'h0_0002, 17'h0_0005);
      push(K_STATE, 17'h0_0000);
      breaker_model_i.set_contacts(1'b0, 1'b0);
      repeat (30 * MSC) @(negedge clock);
      push(K_STATE, 17'h0_0002);
      push(K_STATE, 17'h0_0003);
      push(K_STATE, 17'h0_0002);
      breaker_model_i.set_contacts(1'b0, 1'b1);
      repeat (5) @(negedge clock);
      breaker_model_i.set_contacts(1'b1, 1'b1);
      repeat (5) @(negedge clock);
      breaker_model_i.set_contacts(1'b0, 1'b1);
      settle(2);
      count_clear = 1'b1;
      @(negedge clock);
      count_clear = 1'b0;
      @(negedge clock);
      check_val("count", 17'h0, {1'b0, operation_count});
      self_move(1'b1, 1'b0, 1'b1, 17'h0_0001, 17'h0_0001);
      stuck = 1'b1;
      push(K_CLOSE, 17'h0);
      push(K_WIDTH, 17'h0_000A);
      send(1'b1, 1'b1);
      repeat (10 * MSC - 1) @(negedge clock);
      permits.block_operation = 1'b1;
      settle(2);
      permits.block_operation = 1'b0;
      tally_and_finish();
   end
endmodule
